// ===== src/sbp_boot_port.sv
`include "sbp_cfg.svh"
`default_nettype none
module sbp_boot_port
  import sbp_pkg::*;
#(
  parameter int BIT_MAX_CYC = `SBP_CLK_HZ / `SBP_BAUD_MIN,
  parameter bit LARGE_FLASH = 1'b0,
  parameter int CW          = 18
)(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        mode_pin,
  input  wire logic        host_to_device_line,
  input  wire logic        external_shift_clock_pin,
  input  wire logic        proc_busy,
  input  wire logic        cmd_done,
  input  wire logic [7:0]  be_tx_data,
  input  wire logic        be_tx_valid,
  input  wire logic [15:0] checksum_in,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_is_code,
  output logic             device_to_host_line,
  output sbp_link_t        link_mode,
  output logic             cmd_strobe,
  output sbp_cmd_t         cmd_kind,
  output logic [7:0]       rx_byte,
  output logic             rx_byte_valid,
  output logic             be_tx_ready,
  output logic             boot_rom_sel,
  output logic             flash_hit,
  output logic [14:0]      flash_off,
  output logic             ram_load_hit,
  output logic             security_set
);
  localparam int BIT_MIN_CYC =
    (`SBP_CLK_HZ + `SBP_BAUD_MAX - 1) / `SBP_BAUD_MAX;
  localparam logic [CW-1:0] L1_MIN = CW'(2 * BIT_MIN_CYC);
  localparam logic [CW-1:0] L1_MAX = CW'(2 * BIT_MAX_CYC);

  logic rxd_m_reg, rxd_s_reg, sclk_m_reg, sclk_s_reg, sclk_d_reg;
  logic mode_m_reg, mode_s_reg, prog_en_reg;
  logic [1:0] strap_cnt_reg;
  sbp_state_t state_reg, state_next;
  sbp_link_t  link_reg, link_next;
  logic [CW-1:0] ab_cnt_reg, ab_cnt_next, l1_reg, l1_next;
  logic [15:0] period_reg, period_next;
  logic       send_pend_reg, send_pend_next, hold_reg, line_reg;
  logic [7:0] send_byte_reg, send_byte_next;
  logic       cmd_strobe_reg, cmd_strobe_next, sec_reg, sec_next;
  sbp_cmd_t   cmd_kind_reg, cmd_kind_next;
  logic [7:0] rx_byte_reg;
  logic       rx_byte_valid_reg, be_tx_ready_reg;
  logic       boot_reg, fhit_reg, ram_reg;
  logic [14:0] foff_reg;
  logic [7:0] rx_data;
  logic       rx_valid, tx_busy, tx_shift, txd;

  wire sclk_rise = sclk_s_reg & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s_reg & sclk_d_reg;
  wire sclk_edge = sclk_rise | sclk_fall;
  wire tx_go     = send_pend_reg & ~tx_busy;
  wire [CW-1:0] h1_lo = l1_reg - (l1_reg >> 2);
  wire [CW-1:0] h1_hi = l1_reg + (l1_reg >> 2);
  wire [CW-1:0] l2_lo = l1_reg + (l1_reg >> 1);
  wire [CW-1:0] l2_hi = (l1_reg << 1) + (l1_reg >> 1);
  wire sp_done   = ab_cnt_reg >= CW'(period_reg);
  wire is_m2     = (rx_data == `SBP_MATCH2_A) | (rx_data == `SBP_MATCH2_B);
  wire be_take   = be_tx_valid & be_tx_ready_reg;
  wire flow_low  = hold_reg | ((state_reg == sbp_st_work) & proc_busy);
  wire line_next = (link_reg == sbp_link_sync && !tx_shift) ?
                   ~flow_low : txd;
  wire sbp_cmd_t cmd_lookup =
    (rx_data == `SBP_CMD_ERASE)  ? sbp_cmd_erase  :
    (rx_data == `SBP_CMD_WRITE)  ? sbp_cmd_write  :
    (rx_data == `SBP_CMD_READ)   ? sbp_cmd_read   :
    (rx_data == `SBP_CMD_RAMLD)  ? sbp_cmd_ramld  :
    (rx_data == `SBP_CMD_SUM)    ? sbp_cmd_sum    :
    (rx_data == `SBP_CMD_ID)     ? sbp_cmd_id     :
    (rx_data == `SBP_CMD_STAT)   ? sbp_cmd_stat   :
    (rx_data == `SBP_CMD_EMUL && LARGE_FLASH) ? sbp_cmd_emul :
    (rx_data == `SBP_CMD_SECURE) ? sbp_cmd_secure : sbp_cmd_none;
  // emulation code is ignored on the small flash part
  wire boot_hi_ok = mem_addr <= (mem_is_code ? `SBP_BOOT_CODE_HI :
                                               `SBP_BOOT_DATA_HI);

  sbp_link #(.PW(16)) u_link (
    .clk        (ref_clk),
    .rst        (rst),
    .mode       (link_reg),
    .bit_period (period_reg),
    .rxd        (rxd_s_reg),
    .sclk_rise  (sclk_rise),
    .sclk_fall  (sclk_fall),
    .tx_data    (send_byte_reg),
    .tx_go      (tx_go),
    .rx_data    (rx_data),
    .rx_valid   (rx_valid),
    .tx_busy    (tx_busy),
    .tx_shift   (tx_shift),
    .txd        (txd)
  );

  // pins idle high, so the rxd and sclk synchronisers reset high too; the mode synchroniser resets low
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rxd_m_reg <= 1'b1; rxd_s_reg <= 1'b1; sclk_m_reg <= 1'b1;
      sclk_s_reg <= 1'b1; sclk_d_reg <= 1'b1;
      mode_m_reg <= 1'b0; mode_s_reg <= 1'b0;
    end
    else
    begin
      rxd_m_reg <= host_to_device_line; rxd_s_reg <= rxd_m_reg;
      sclk_m_reg <= external_shift_clock_pin; sclk_s_reg <= sclk_m_reg;
      sclk_d_reg <= sclk_s_reg;
      mode_m_reg <= mode_pin; mode_s_reg <= mode_m_reg;
    end
  end

  // mode strap caught once the synchroniser has settled after release
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_cnt_reg <= 2'h0;
      prog_en_reg   <= 1'b0;
    end
    else if (strap_cnt_reg != `SBP_STRAP_CYC)
    begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      prog_en_reg   <= mode_s_reg;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    link_next = link_reg;
    ab_cnt_next = ab_cnt_reg + 1'b1;
    l1_next = l1_reg;
    period_next = period_reg;
    send_pend_next = send_pend_reg & ~tx_go;
    send_byte_next = send_byte_reg;
    cmd_strobe_next = 1'b0;
    cmd_kind_next = cmd_kind_reg;
    sec_next = 1'b0;
    case (state_reg)
      sbp_st_idle:
      begin
        ab_cnt_next = CW'(1);
        if (prog_en_reg && rx_valid && rx_data == `SBP_MATCH1_SYNC)
        begin
          link_next = sbp_link_sync;
          send_pend_next = 1'b1;
          send_byte_next = rx_data;
          state_next = sbp_st_match;
        end
        else if (prog_en_reg && !rxd_s_reg && !sclk_edge)
          state_next = sbp_st_ab_l1; // other bytes are dropped
      end
      // start plus bit0 low, two high, four low: widths 2:2:4
      sbp_st_ab_l1:
        if (sclk_edge || ab_cnt_reg > L1_MAX)
          state_next = sbp_st_idle;
        else if (rxd_s_reg)
        begin
          state_next = (ab_cnt_reg < L1_MIN) ? sbp_st_idle : sbp_st_ab_h1;
          l1_next = ab_cnt_reg;
          ab_cnt_next = CW'(1);
        end
      sbp_st_ab_h1:
        if (sclk_edge || ab_cnt_reg > h1_hi)
          state_next = sbp_st_idle;
        else if (!rxd_s_reg)
        begin
          state_next = (ab_cnt_reg < h1_lo) ? sbp_st_idle : sbp_st_ab_l2;
          ab_cnt_next = CW'(1);
        end
      sbp_st_ab_l2:
        if (sclk_edge || ab_cnt_reg > l2_hi)
          state_next = sbp_st_idle;
        else if (rxd_s_reg)
        begin
          state_next = (ab_cnt_reg < l2_lo) ? sbp_st_idle : sbp_st_ab_sp;
          period_next = 16'(l1_reg >> 1);
          ab_cnt_next = CW'(1);
        end
      sbp_st_ab_sp:
        if (!rxd_s_reg || sclk_edge)
          state_next = sbp_st_idle;
        else if (sp_done)
        begin
          link_next = sbp_link_uart;
          send_pend_next = 1'b1;
          send_byte_next = `SBP_MATCH1_UART;
          state_next = sbp_st_match;
        end
      sbp_st_match:
        if (rx_valid && is_m2)
        begin
          send_pend_next = 1'b1;
          send_byte_next = rx_data;
          state_next = sbp_st_cmd;
        end
      sbp_st_cmd:
        if (rx_valid && cmd_lookup != sbp_cmd_none)
        begin
          cmd_strobe_next = 1'b1;
          cmd_kind_next = cmd_lookup;
          send_pend_next = 1'b1;
          send_byte_next = rx_data;
          sec_next = (cmd_lookup == sbp_cmd_secure);
          if (cmd_lookup == sbp_cmd_sum)
          begin
            send_byte_next = `SBP_CHECK_BYTE;
            state_next = sbp_st_sum1;
          end
          else if (cmd_lookup != sbp_cmd_secure &&
                   cmd_lookup != sbp_cmd_emul)
            state_next = sbp_st_work;
        end
      sbp_st_sum1:
        if (!send_pend_reg)
        begin
          send_pend_next = 1'b1; // upper byte first
          send_byte_next = checksum_in[15:8];
          state_next = sbp_st_sum2;
        end
      sbp_st_sum2:
        if (!send_pend_reg)
        begin
          send_pend_next = 1'b1;
          send_byte_next = checksum_in[7:0];
          state_next = sbp_st_cmd;
        end
      sbp_st_work:
      begin
        if (be_take)
        begin
          send_pend_next = 1'b1;
          send_byte_next = be_tx_data;
        end
        if (cmd_done)
          state_next = sbp_st_cmd;
      end
      default:
        state_next = sbp_st_idle;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= sbp_st_idle; link_reg <= sbp_link_none;
      ab_cnt_reg <= '0; l1_reg <= '0; period_reg <= 16'h0001;
      send_pend_reg <= 1'b0; send_byte_reg <= 8'h00;
      cmd_strobe_reg <= 1'b0; cmd_kind_reg <= sbp_cmd_none;
      sec_reg <= 1'b0; hold_reg <= 1'b0; line_reg <= 1'b1;
      rx_byte_reg <= 8'h00; rx_byte_valid_reg <= 1'b0;
      be_tx_ready_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next; link_reg <= link_next;
      ab_cnt_reg <= ab_cnt_next; l1_reg <= l1_next;
      period_reg <= period_next;
      send_pend_reg <= send_pend_next; send_byte_reg <= send_byte_next;
      cmd_strobe_reg <= cmd_strobe_next; cmd_kind_reg <= cmd_kind_next;
      sec_reg <= sec_next;
      hold_reg <= rx_valid; // a byte just arrived and is being decided
      line_reg <= line_next;
      rx_byte_reg <= rx_data;
      rx_byte_valid_reg <= rx_valid & (state_reg == sbp_st_work);
      be_tx_ready_reg <= (state_next == sbp_st_work) & ~send_pend_next;
    end
  end

  // address map only holds while the strap says programming mode
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      boot_reg <= 1'b0; fhit_reg <= 1'b0; ram_reg <= 1'b0;
      foff_reg <= 15'h0000;
    end
    else
    begin
      boot_reg <= prog_en_reg & (mem_addr >= `SBP_BOOT_LO) & boot_hi_ok;
      fhit_reg <= prog_en_reg & (mem_addr >= `SBP_FLASH_LO);
      foff_reg <= mem_addr[14:0];
      ram_reg  <= prog_en_reg & (mem_addr >= `SBP_RAM_LO) &
                  (mem_addr <= `SBP_RAM_HI);
    end
  end

  assign device_to_host_line = line_reg;
  assign link_mode     = link_reg;
  assign cmd_strobe    = cmd_strobe_reg;
  assign cmd_kind      = cmd_kind_reg;
  assign rx_byte       = rx_byte_reg;
  assign rx_byte_valid = rx_byte_valid_reg;
  assign be_tx_ready   = be_tx_ready_reg;
  assign boot_rom_sel  = boot_reg;
  assign flash_hit     = fhit_reg;
  assign flash_off     = foff_reg;
  assign ram_load_hit  = ram_reg;
  assign security_set  = sec_reg;

  property p_sync_sel;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == sbp_st_idle && prog_en_reg && rx_valid &&
     rx_data == `SBP_MATCH1_SYNC) |=> link_mode == sbp_link_sync;
  endproperty
  a_sync_sel: assert property (p_sync_sel)
    else $error("first byte 0x30 did not select clocked link");

  property p_uart_sel;
    @(posedge ref_clk) disable iff (rst)
    $rose(link_mode == sbp_link_uart) |->
      $past(state_reg) == sbp_st_ab_sp && send_pend_reg &&
      send_byte_reg == `SBP_MATCH1_UART;
  endproperty
  a_uart_sel: assert property (p_uart_sel)
    else $error("uart chosen without measured 0x86 and echo");

  property p_standby;
    @(posedge ref_clk) disable iff (rst)
    link_mode == sbp_link_none |-> !cmd_strobe && !rx_byte_valid;
  endproperty
  a_standby: assert property (p_standby)
    else $error("command activity before setup exchange");

  property p_bad_first;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == sbp_st_idle && rx_valid &&
     rx_data != `SBP_MATCH1_SYNC) |=> link_mode == sbp_link_none;
  endproperty
  a_bad_first: assert property (p_bad_first)
    else $error("link chosen after a non-matching first byte");

  property p_flow;
    @(posedge ref_clk) disable iff (rst)
    (link_mode == sbp_link_sync && hold_reg && !tx_shift) |=>
      !device_to_host_line;
  endproperty
  a_flow: assert property (p_flow)
    else $error("data-out not low while a byte is in process");

  property p_match2_err;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == sbp_st_match && rx_valid && !is_m2 && !send_pend_reg)
      |=> !send_pend_reg && state_reg == sbp_st_match;
  endproperty
  a_match2_err: assert property (p_match2_err)
    else $error("reply sent to a bad second match byte");

  property p_sum;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == sbp_st_cmd && rx_valid && rx_data == `SBP_CMD_SUM)
      |=> send_byte_reg == `SBP_CHECK_BYTE && cmd_kind == sbp_cmd_sum;
  endproperty
  a_sum: assert property (p_sum)
    else $error("sum command did not lead with check byte");

  property p_flash_map;
    @(posedge ref_clk) disable iff (rst)
    flash_hit |-> flash_off == $past(mem_addr[14:0]) &&
                  $past(mem_addr[15]);
  endproperty
  a_flash_map: assert property (p_flash_map)
    else $error("flash offset does not match host address");

  property p_boot_map;
    @(posedge ref_clk) disable iff (rst)
    (prog_en_reg && !mem_is_code && mem_addr == `SBP_BOOT_CODE_HI)
      |=> !boot_rom_sel;
  endproperty
  a_boot_map: assert property (p_boot_map)
    else $error("boot rom decoded above data window");

  property p_erase;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == sbp_st_cmd && rx_valid && rx_data == `SBP_CMD_ERASE)
      |=> cmd_strobe && cmd_kind == sbp_cmd_erase ##1 !cmd_strobe;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase code not decoded");
endmodule : sbp_boot_port
`default_nettype wire

// ===== src/sbp_cfg.svh
`ifndef SBP_CFG_SVH
`define SBP_CFG_SVH
`define SBP_CLK_HZ 100000000
`define SBP_BAUD_MIN 9600
`define SBP_BAUD_MAX 128000
`define SBP_MATCH1_UART 8'h86
`define SBP_MATCH1_SYNC 8'h30
`define SBP_MATCH2_A 8'h79
`define SBP_MATCH2_B 8'hCF
`define SBP_CMD_ERASE 8'hF0
`define SBP_CMD_WRITE 8'h30
`define SBP_CMD_READ 8'h40
`define SBP_CMD_RAMLD 8'h60
`define SBP_CMD_SUM 8'h90
`define SBP_CMD_ID 8'hC0
`define SBP_CMD_STAT 8'hC3
`define SBP_CMD_EMUL 8'hD0
`define SBP_CMD_SECURE 8'hFA
`define SBP_CHECK_BYTE 8'hFF
`define SBP_BOOT_LO 16'h1000
`define SBP_BOOT_DATA_HI 16'h17FF
`define SBP_BOOT_CODE_HI 16'h1FFF
`define SBP_FLASH_LO 16'h8000
`define SBP_RAM_LO 16'h0060
`define SBP_RAM_HI 16'h083F
`define SBP_DATA_BITS 8
`define SBP_UART_FRAME_BITS 10
`define SBP_STRAP_CYC 2'h3
`endif

// ===== src/sbp_pkg.sv
`default_nettype none
package sbp_pkg;
  typedef enum logic [1:0] {
    sbp_link_none = 2'b00,
    sbp_link_uart = 2'b01,
    sbp_link_sync = 2'b10
  } sbp_link_t;

  typedef enum logic [3:0] {
    sbp_st_idle  = 4'b0000,
    sbp_st_ab_l1 = 4'b0001,
    sbp_st_ab_h1 = 4'b0010,
    sbp_st_ab_l2 = 4'b0011,
    sbp_st_ab_sp = 4'b0100,
    sbp_st_match = 4'b0101,
    sbp_st_cmd   = 4'b0110,
    sbp_st_sum1  = 4'b0111,
    sbp_st_sum2  = 4'b1000,
    sbp_st_work  = 4'b1001
  } sbp_state_t;

  typedef enum logic [3:0] {
    sbp_cmd_none   = 4'b0000,
    sbp_cmd_erase  = 4'b0001,
    sbp_cmd_write  = 4'b0010,
    sbp_cmd_read   = 4'b0011,
    sbp_cmd_ramld  = 4'b0100,
    sbp_cmd_sum    = 4'b0101,
    sbp_cmd_id     = 4'b0110,
    sbp_cmd_stat   = 4'b0111,
    sbp_cmd_emul   = 4'b1000,
    sbp_cmd_secure = 4'b1001
  } sbp_cmd_t;
endpackage : sbp_pkg
`default_nettype wire

// ===== src/sbp_link.sv
`include "sbp_cfg.svh"
`default_nettype none
module sbp_link
  import sbp_pkg::*;
#(
  parameter int PW = 16
)(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire sbp_link_t     mode,
  input  wire logic [PW-1:0] bit_period,
  input  wire logic          rxd,
  input  wire logic          sclk_rise,
  input  wire logic          sclk_fall,
  input  wire logic [7:0]    tx_data,
  input  wire logic          tx_go,
  output logic      [7:0]    rx_data,
  output logic               rx_valid,
  output logic               tx_busy,
  output logic               tx_shift,
  output logic               txd
);
  logic          urx_on;
  logic [PW-1:0] ucnt;
  logic [3:0]    ubit;
  logic [7:0]    ush;
  logic [2:0]    scnt;
  logic [7:0]    ssh;
  logic [9:0]    tsh;
  logic [PW-1:0] tcnt;
  logic [3:0]    tbit;

  wire is_uart = (mode == sbp_link_uart);
  wire ucnt_zero = (ucnt == '0);
  wire tcnt_zero = (tcnt == '0);

  // receive: uart samples mid-bit, otherwise the host's shift clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      urx_on <= 1'b0; ucnt <= '0; ubit <= 4'h0; ush <= 8'h00;
      scnt <= 3'h0; ssh <= 8'h00; rx_data <= 8'h00; rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (is_uart)
      begin
        if (!urx_on)
        begin
          if (!rxd)
          begin
            urx_on <= 1'b1;
            ucnt   <= bit_period >> 1;
            ubit   <= 4'h0;
          end
        end
        else if (!ucnt_zero)
          ucnt <= ucnt - 1'b1;
        else
        begin
          ucnt <= bit_period - 1'b1;
          ubit <= ubit + 4'h1;
          if (ubit == 4'h0 && rxd)
            urx_on <= 1'b0; // glitch, not a start bit
          else if (ubit == 4'(`SBP_UART_FRAME_BITS - 1))
          begin
            urx_on <= 1'b0;
            rx_valid <= rxd; // 8 data, no parity, one stop
            rx_data  <= ush;
          end
          else if (ubit != 4'h0)
            ush <= {rxd, ush[7:1]}; // lsb first
        end
      end
      else if (sclk_rise) // device is slave to host clock
      begin
        ssh  <= {rxd, ssh[7:1]};
        scnt <= scnt + 3'h1;
        if (scnt == 3'(`SBP_DATA_BITS - 1))
        begin
          rx_valid <= 1'b1;
          rx_data  <= {rxd, ssh[7:1]};
        end
      end
    end
  end

  // transmit: in clocked mode the first bit appears at the first fall
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_busy <= 1'b0; tx_shift <= 1'b0; txd <= 1'b1;
      tsh <= 10'h3FF; tcnt <= '0; tbit <= 4'h0;
    end
    else if (tx_go && !tx_busy)
    begin
      tx_busy <= 1'b1;
      tbit    <= 4'h0;
      tcnt    <= bit_period - 1'b1;
      tsh     <= is_uart ? {1'b1, tx_data, 1'b0} : {2'b11, tx_data};
      tx_shift <= is_uart;
      txd     <= is_uart ? 1'b0 : 1'b1; // start bit in uart mode; high in clocked mode until the first fall
    end
    else if (tx_busy && is_uart)
    begin
      if (!tcnt_zero)
        tcnt <= tcnt - 1'b1;
      else
      begin
        tcnt <= bit_period - 1'b1;
        tbit <= tbit + 4'h1;
        tsh  <= {1'b1, tsh[9:1]};
        txd  <= tsh[1];
        if (tbit == 4'(`SBP_UART_FRAME_BITS - 1))
        begin
          tx_busy  <= 1'b0;
          tx_shift <= 1'b0;
          txd      <= 1'b1;
        end
      end
    end
    else if (tx_busy)
    begin
      if (sclk_fall)
      begin
        txd      <= tsh[0];
        tsh      <= {1'b1, tsh[9:1]};
        tx_shift <= 1'b1;
      end
      if (sclk_rise && tx_shift)
      begin
        tbit <= tbit + 4'h1;
        if (tbit == 4'(`SBP_DATA_BITS - 1))
        begin
          tx_busy  <= 1'b0;
          tx_shift <= 1'b0;
        end
      end
    end
  end
endmodule : sbp_link
`default_nettype wire

// ===== tb/sbp_host_model.sv
`default_nettype none
module sbp_host_model (
  input  wire logic clk,
  input  wire logic dev_line,
  output logic      h2d_line,
  output logic      sclk_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BT = 868; // 115200 bps at 100 MHz
  initial h2d_line = 1'b1;
  initial sclk_pin = 1'b1;
  task automatic uart_send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      h2d_line = f[i];
      repeat (BT) @(negedge clk);
    end
  endtask : uart_send
  task automatic uart_recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (dev_line !== 1'b0 && n < 12000)
    begin
      @(negedge clk);
      n++;
    end
    ok = (n < 12000);
    if (ok)
    begin
      repeat (BT + BT / 2) @(negedge clk);
      for (int i = 0; i < 8; i++)
      begin
        b[i] = dev_line;
        repeat (BT) @(negedge clk);
      end
    end
  endtask : uart_recv
  // gap first: the flow level may still show ready just after a burst
  task automatic sync_xfer(input logic [7:0] t, output logic [7:0] r,
                           output logic ok);
    int n;
    n = 0;
    repeat (20) @(negedge clk);
    while (dev_line !== 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    ok = (n < 2000);
    // 125 ns shift clock, offset so no pin moves on a clock edge
    #2;
    for (int i = 0; i < 8; i++)
    begin
      sclk_pin = 1'b0;
      h2d_line = t[i];
      #62;
      r[i] = dev_line;
      sclk_pin = 1'b1;
      #63;
    end
    h2d_line = 1'b1;
    @(negedge clk);
  endtask : sync_xfer
endmodule : sbp_host_model
`default_nettype wire

// ===== tb/serial_boot_programming_port_tb_top.sv
`default_nettype none
module serial_boot_programming_port_tb_top import sbp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, rst, mode_pin, h2d, sclk, d2h, code;
  logic        boot, fl, ram;
  logic        busy, done, be_valid, stb, sec, rxv, be_rdy;
  logic [7:0]  be_data, rxb, rx_seen;
  logic [15:0] n_stb, n_sec;
  logic [15:0] addr;
  logic [14:0] foff;
  sbp_link_t   link;
  sbp_cmd_t    kind;
  int          n_tests = 0;
  int          miscompares = 0;
  sbp_boot_port DUT (
    .ref_clk(ref_clk), .rst(rst), .mode_pin(mode_pin),
    .host_to_device_line(h2d), .external_shift_clock_pin(sclk),
    .proc_busy(busy), .cmd_done(done), .be_tx_data(be_data),
    .be_tx_valid(be_valid), .checksum_in(16'hA55A), .mem_addr(addr),
    .mem_is_code(code), .device_to_host_line(d2h), .link_mode(link),
    .cmd_strobe(stb), .cmd_kind(kind), .rx_byte(rxb),
    .rx_byte_valid(rxv), .be_tx_ready(be_rdy), .boot_rom_sel(boot),
    .flash_hit(fl), .flash_off(foff), .ram_load_hit(ram),
    .security_set(sec)
  );
  // one-cycle pulses are counted at the falling edge, where they stand
  always @(negedge ref_clk)
  begin
    if (stb)
      n_stb++;
    if (sec)
      n_sec++;
    if (rxv)
      rx_seen = rxb;
  end
  sbp_host_model HOST (
    .clk(ref_clk), .dev_line(d2h), .h2d_line(h2d), .sclk_pin(sclk)
  );
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic do_reset;
    rst = 1'b1;
    mode_pin = 1'b0;
    n_stb = 16'h0000;
    n_sec = 16'h0000;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    mode_pin = 1'b1;
    repeat (5) @(negedge ref_clk);
  endtask : do_reset
  task automatic t_uart;
    logic [7:0] b0, b1, b2;
    logic       ok;
    do_reset();
    fork HOST.uart_send(8'h55); HOST.uart_recv(b0, ok); join
    chk("bad echo", 16'h0000, {15'h0, ok});
    chk("bad link", sbp_link_none, link);
    fork HOST.uart_send(8'h86); HOST.uart_recv(b0, ok); join
    chk("echo1", 16'h0086, b0);
    chk("link", sbp_link_uart, link);
    fork HOST.uart_send(8'h79); HOST.uart_recv(b0, ok); join
    chk("echo2", 16'h0079, b0);
    fork
      HOST.uart_send(8'h90);
      begin
        HOST.uart_recv(b0, ok);
        HOST.uart_recv(b1, ok);
        HOST.uart_recv(b2, ok);
      end
    join
    chk("check", 16'h00FF, b0);
    chk("sum", 16'hA55A, {b1, b2});
    chk("kind", sbp_cmd_sum, kind);
    chk("strobe", 16'h0001, n_stb);
  endtask : t_uart
  task automatic probe(input logic [15:0] a, input logic c,
                       input logic [2:0] e);
    addr = a;
    code = c;
    repeat (2) @(negedge ref_clk);
    chk("map", {13'h0, e}, {13'h0, boot, fl, ram});
  endtask : probe
  task automatic t_map;
    probe(16'h1000, 1'b0, 3'b100);
    probe(16'h17FF, 1'b0, 3'b100);
    probe(16'h1800, 1'b0, 3'b000);
    probe(16'h1800, 1'b1, 3'b100);
    probe(16'h1FFF, 1'b1, 3'b100);
    probe(16'h1FFF, 1'b0, 3'b000);
    probe(16'h2000, 1'b1, 3'b000);
    probe(16'h7FFF, 1'b0, 3'b000);
    probe(16'h8000, 1'b0, 3'b010);
    probe(16'hFFFF, 1'b0, 3'b010);
    chk("offset", 16'h7FFF, {1'b0, foff});
    probe(16'h005F, 1'b0, 3'b000);
    probe(16'h0060, 1'b0, 3'b001);
    probe(16'h083F, 1'b0, 3'b001);
    probe(16'h0840, 1'b0, 3'b000);
  endtask : t_map
  task automatic t_sync;
    logic [7:0] r;
    logic       ok;
    int         n;
    do_reset();
    HOST.sync_xfer(8'h55, r, ok);
    chk("bad first", 16'h00FF, r);
    chk("bad link", sbp_link_none, link);
    HOST.sync_xfer(8'h30, r, ok);
    repeat (5) @(negedge ref_clk);
    chk("link", sbp_link_sync, link);
    HOST.sync_xfer(8'h55, r, ok);
    chk("echo1", 16'h0030, r);
    HOST.sync_xfer(8'h79, r, ok);
    chk("bad m2", 16'h00FF, r);
    HOST.sync_xfer(8'hFA, r, ok);
    chk("echo2", 16'h0079, r);
    chk("secure", 16'h0001, n_sec);
    HOST.sync_xfer(8'hD0, r, ok);
    chk("echo3", 16'h00FA, r);
    HOST.sync_xfer(8'hC0, r, ok);
    chk("emul", 16'h00FF, r);
    chk("kind", sbp_cmd_id, kind);
    busy = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("busy", 16'h0000, {15'h0, d2h});
    busy = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("ready", 16'h0001, {15'h0, d2h});
    be_data = 8'h3C;
    be_valid = 1'b1;
    n = 0;
    while (!be_rdy && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("be take", 16'h0001, {15'h0, be_rdy});
    @(negedge ref_clk);
    be_valid = 1'b0;
    chk("be hold", 16'h0000, {15'h0, be_rdy});
    HOST.sync_xfer(8'h5A, r, ok);
    chk("echo4", 16'h00C0, r);
    chk("rx", 16'h005A, {8'h00, rx_seen});
    HOST.sync_xfer(8'h00, r, ok);
    chk("reply", 16'h003C, r);
    done = 1'b1;
    @(negedge ref_clk);
    done = 1'b0;
    HOST.sync_xfer(8'hF0, r, ok);
    chk("kind", sbp_cmd_erase, kind);
    chk("strobes", 16'h0003, n_stb);
    chk("flow", 16'h0001, {15'h0, ok});
  endtask : t_sync
  // hang guard, about a quarter above the longest expected run (about 80000 cycles)
  initial
  begin
    repeat (100000) @(negedge ref_clk);
    miscompares++;
    tally_and_finish();
  end
  initial
  begin
    rst = 1'b1;
    mode_pin = 1'b0;
    addr = 16'h0000;
    code = 1'b0;
    busy = 1'b0;
    done = 1'b0;
    be_valid = 1'b0;
    be_data = 8'h00;
    rx_seen = 8'h00;
    t_uart();
    t_map();
    t_sync();
    tally_and_finish();
  end
endmodule : serial_boot_programming_port_tb_top
`default_nettype wire
